// >>> verilog/span_alarm_pkg.sv
/*
 * constants and types shared by the span calibration and concentration alarm logic.
 * assumes a 20 MHz system clock.
 */
package span_alarm_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int PPM_WIDTH = 24;
    localparam int ALARM_COUNT = 2;
    localparam int HOLD_MIN_DEFAULT = 5;
    localparam int HOLD_MIN_LOW = 1;
    localparam int HOLD_MIN_HIGH = 60;
    localparam int MINUTE_S = 60;
    localparam int MINUTE_CYCLES = CLK_HZ * MINUTE_S;
    localparam int FAIL_MSG_S = 5;
    localparam int FAIL_MSG_CYCLES = CLK_HZ * FAIL_MSG_S;
    localparam int SAMPLE_MS = 1000;
    localparam int SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;
    // sensitivity floor in nA per ppm: 0.5 uA/ppm
    localparam int SENS_MIN_NA = 500;
    localparam int TOLERANCE_PPM = 1;
    // APB register byte offsets
    localparam logic [7:0] SPAN_CTRL_ADDR = 8'h00;
    localparam logic [7:0] SPAN_GAS_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] SLOPE_ADDR = 8'h0C;
    localparam logic [7:0] ALARM_CFG0_ADDR = 8'h10;
    localparam logic [7:0] ALARM_SET0_ADDR = 8'h14;
    localparam logic [7:0] ALARM_CFG1_ADDR = 8'h18;
    localparam logic [7:0] ALARM_SET1_ADDR = 8'h1C;
    localparam logic [7:0] PASSWORD_ADDR = 8'h20;
    localparam logic [31:0] PASSWORD_DEFAULT = 32'h0000_1234;
    // alarm config field positions
    localparam int CFG_HIGH_BIT = 0;
    localparam int CFG_DEFEAT_BIT = 1;
    localparam int CFG_FAILSAFE_BIT = 2;
    localparam int CFG_LATCH_BIT = 3;
    localparam logic [3:0] CFG_RESET = 4'h1;
    localparam logic [23:0] SETPOINT_RESET = 24'h000064;
    typedef enum logic [2:0] {ANALYZE, SETTLE, HOLD, CHECK, FAILMSG} span_state_type;
endpackage : span_alarm_pkg

// >>> verilog/conc_alarm_channel.sv
/*
 * one concentration alarm: compare, latch, defeat and relay polarity.
 * assumes configuration writes arrive as registered levels.
 */
`timescale 1ns/1ps
`default_nettype none
module conc_alarm_channel
    import span_alarm_pkg::*;
#(
    parameter int WIDTH = PPM_WIDTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic analyzeMode,
    input wire logic [WIDTH-1:0] concentration,
    input wire logic [WIDTH-1:0] setpoint,
    input wire logic tripHigh,
    input wire logic defeat,
    input wire logic relayDeenergizeOnTrip,
    input wire logic latching,
    output logic alarmActive,
    output logic relayEnergize
);
    logic latched;
    logic defeatSeen;
    logic unlatchSeen;
    logic defeatPrev;
    logic latchPrev;
    wire above = concentration > setpoint;
    wire below = concentration < setpoint;
    wire condition = analyzeMode && !defeat && (tripHigh ? above : below);
    // defeat yes then no, or latching no then yes, clears the held trip
    wire defeatReset = defeatPrev && !defeat && defeatSeen;
    wire latchReset = !latchPrev && latching && unlatchSeen;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latched <= 1'b0;
            defeatPrev <= 1'b0;
            latchPrev <= 1'b0;
            defeatSeen <= 1'b0;
            unlatchSeen <= 1'b0;
        end else begin
            defeatPrev <= defeat;
            latchPrev <= latching;
            defeatSeen <= defeat;
            unlatchSeen <= !latching;
            if (defeatReset || latchReset || !latching) begin
                latched <= 1'b0;
            end else if (condition) begin
                latched <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alarmActive <= 1'b0;
            relayEnergize <= 1'b0;
        end else begin
            alarmActive <= condition || (latching && latched && !defeat);
            relayEnergize <= (condition || (latching && latched && !defeat))
                ^ relayDeenergizeOnTrip;
        end
    end
endmodule : conc_alarm_channel
`default_nettype wire

// >>> verilog/slope_meter.sv
/*
 * samples the reading at a fixed rate and reports successive differences.
 * assumes the reading is a ppm value synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module slope_meter
    import span_alarm_pkg::*;
#(
    parameter int WIDTH = PPM_WIDTH,
    parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [WIDTH-1:0] reading,
    output logic [WIDTH-1:0] slope,
    output logic sampleTick
);
    logic [31:0] count;
    logic [WIDTH-1:0] lastSample;
    wire tick = run && (count == 32'(SAMPLE_PERIOD - 1));
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
            lastSample <= '0;
            slope <= '0;
            sampleTick <= 1'b0;
        end else begin
            sampleTick <= tick;
            if (!run) begin
                count <= '0;
                lastSample <= reading;
            end else if (tick) begin
                count <= '0;
                lastSample <= reading;
                slope <= reading - lastSample;
            end else begin
                count <= count + 32'h1;
            end
        end
    end
endmodule : slope_meter
`default_nettype wire

// >>> verilog/span_alarm_control.sv
/*
 * span calibration sequencing and two concentration alarms behind an APB slave.
 * assumes key presses are one-cycle pulses and the reading is synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module span_alarm_control
    import span_alarm_pkg::*;
#(
    parameter int WIDTH = PPM_WIDTH,
    parameter int MINUTE_PERIOD = MINUTE_CYCLES,
    parameter int FAIL_PERIOD = FAIL_MSG_CYCLES,
    parameter int SAMPLE_PERIOD = SAMPLE_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spanKey,
    input wire logic enterKey,
    input wire logic analyzeKey,
    input wire logic [WIDTH-1:0] reading,
    input wire logic [15:0] cellSensitivityNa,
    input wire logic [WIDTH-1:0] spanCalIn,
    output logic [WIDTH-1:0] spanCal,
    output logic spanActive,
    output logic spanFailedMessage,
    output logic calibration_failed_flag,
    output logic systemAlarmRelay,
    output logic first_concentration_alarm,
    output logic second_concentration_alarm,
    output logic firstAlarmRelay,
    output logic secondAlarmRelay
);
    span_state_type state;
    span_state_type next_state;
    logic autoMode;
    logic passwordEnable;
    logic unlocked;
    logic [5:0] holdMinutes;
    logic [WIDTH-1:0] spanGas;
    logic [WIDTH-1:0] savedCal;
    logic [31:0] timer;
    logic [5:0] minutesLeft;
    logic [3:0] alarmCfg [ALARM_COUNT];
    logic [WIDTH-1:0] alarmSet [ALARM_COUNT];
    logic [ALARM_COUNT-1:0] alarmActive;
    logic [ALARM_COUNT-1:0] relay;
    logic [WIDTH-1:0] slope;

    wire writeStrobe = psel && penable && pwrite;
    wire cfgWritable = !passwordEnable || unlocked;
    wire [WIDTH-1:0] diff = (reading > spanGas) ? reading - spanGas : spanGas - reading;
    wire matched = diff <= WIDTH'(TOLERANCE_PPM);
    wire sensOk = cellSensitivityNa >= 16'(SENS_MIN_NA);
    wire minuteDone = timer == 32'(MINUTE_PERIOD - 1);
    wire failDone = timer == 32'(FAIL_PERIOD - 1);
    wire [5:0] holdWrite = pwdata[13:8];
    wire holdInRange = holdWrite >= 6'(HOLD_MIN_LOW) && holdWrite <= 6'(HOLD_MIN_HIGH);
    wire analyzeMode = state == ANALYZE;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign spanActive = state == SETTLE || state == HOLD || state == CHECK;
    assign spanFailedMessage = state == FAILMSG;
    assign first_concentration_alarm = alarmActive[0];
    assign second_concentration_alarm = alarmActive[1];
    assign firstAlarmRelay = relay[0];
    assign secondAlarmRelay = relay[1];

    slope_meter #(
        .WIDTH(WIDTH),
        .SAMPLE_PERIOD(SAMPLE_PERIOD)
    ) u_slope (
        .clk(clk),
        .reset_n(reset_n),
        .run(spanActive),
        .reading(reading),
        .slope(slope),
        .sampleTick()
    );

    genvar g;
    generate
        for (g = 0; g < ALARM_COUNT; g++) begin : g_alarm
            conc_alarm_channel #(
                .WIDTH(WIDTH)
            ) u_alarm (
                .clk(clk),
                .reset_n(reset_n),
                .analyzeMode(analyzeMode),
                .concentration(reading),
                .setpoint(alarmSet[g]),
                .tripHigh(alarmCfg[g][CFG_HIGH_BIT]),
                .defeat(alarmCfg[g][CFG_DEFEAT_BIT]),
                .relayDeenergizeOnTrip(alarmCfg[g][CFG_FAILSAFE_BIT]),
                .latching(alarmCfg[g][CFG_LATCH_BIT]),
                .alarmActive(alarmActive[g]),
                .relayEnergize(relay[g])
            );
        end
    endgenerate

    always_comb begin
        next_state = state;
        case (state)
            ANALYZE: begin
                if (spanKey) begin
                    next_state = SETTLE;
                end
            end
            SETTLE: begin
                if (analyzeKey) begin
                    next_state = ANALYZE;
                end else if (autoMode && matched) begin
                    next_state = HOLD;
                end else if (!autoMode && enterKey) begin
                    next_state = CHECK;
                end
            end
            HOLD: begin
                if (analyzeKey) begin
                    next_state = ANALYZE;
                end else if (minuteDone && minutesLeft == 6'd1) begin
                    next_state = CHECK;
                end
            end
            CHECK: begin
                next_state = sensOk ? ANALYZE : FAILMSG;
            end
            FAILMSG: begin
                if (failDone) begin
                    next_state = ANALYZE;
                end
            end
            default: begin
                next_state = ANALYZE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ANALYZE;
            timer <= '0;
            minutesLeft <= '0;
        end else begin
            state <= next_state;
            if (next_state != state || (state == HOLD && minuteDone)) begin
                timer <= '0;
            end else begin
                timer <= timer + 32'h1;
            end
            if (state == SETTLE) begin
                minutesLeft <= holdMinutes;
            end else if (state == HOLD && minuteDone) begin
                minutesLeft <= minutesLeft - 6'd1;
            end
        end
    end

    // calibration: saved at span start, replaced on success, restored on reject
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            spanCal <= '0;
            savedCal <= '0;
        end else if (state == ANALYZE && spanKey) begin
            savedCal <= spanCalIn;
            spanCal <= spanCalIn;
        end else if (state == CHECK) begin
            spanCal <= sensOk ? spanGas : savedCal;
        end
    end

    // only reset_n (standby power cycle) clears the failure state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            calibration_failed_flag <= 1'b0;
            systemAlarmRelay <= 1'b0;
        end else if (state == CHECK && !sensOk) begin
            calibration_failed_flag <= 1'b1;
            systemAlarmRelay <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            autoMode <= 1'b1;
            holdMinutes <= 6'(HOLD_MIN_DEFAULT);
            spanGas <= '0;
            passwordEnable <= 1'b0;
            unlocked <= 1'b0;
            for (int i = 0; i < ALARM_COUNT; i++) begin
                alarmCfg[i] <= CFG_RESET;
                alarmSet[i] <= SETPOINT_RESET[WIDTH-1:0];
            end
        end else if (writeStrobe) begin
            case (paddr)
                SPAN_CTRL_ADDR: begin
                    autoMode <= pwdata[0];
                    passwordEnable <= pwdata[1];
                    if (holdInRange) begin
                        holdMinutes <= holdWrite;
                    end
                end
                SPAN_GAS_ADDR: spanGas <= pwdata[WIDTH-1:0];
                PASSWORD_ADDR: unlocked <= pwdata == PASSWORD_DEFAULT;
                ALARM_CFG0_ADDR: if (cfgWritable) alarmCfg[0] <= pwdata[3:0];
                ALARM_SET0_ADDR: if (cfgWritable) alarmSet[0] <= pwdata[WIDTH-1:0];
                ALARM_CFG1_ADDR: if (cfgWritable) alarmCfg[1] <= pwdata[3:0];
                ALARM_SET1_ADDR: if (cfgWritable) alarmSet[1] <= pwdata[WIDTH-1:0];
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        prdata = 32'h0;
        case (paddr)
            SPAN_CTRL_ADDR: prdata = {18'h0, holdMinutes, 6'h0, passwordEnable, autoMode};
            SPAN_GAS_ADDR: prdata = 32'(spanGas);
            STATUS_ADDR: prdata = {24'h0, unlocked, systemAlarmRelay, calibration_failed_flag,
                spanFailedMessage, spanActive, 1'b0, alarmActive};
            SLOPE_ADDR: prdata = 32'(slope);
            ALARM_CFG0_ADDR: prdata = {28'h0, alarmCfg[0]};
            ALARM_SET0_ADDR: prdata = 32'(alarmSet[0]);
            ALARM_CFG1_ADDR: prdata = {28'h0, alarmCfg[1]};
            ALARM_SET1_ADDR: prdata = 32'(alarmSet[1]);
            default: prdata = 32'h0;
        endcase
    end
endmodule : span_alarm_control
`default_nettype wire

// >>> tb/span_alarm_chk.sv
/*
 * assertion checker for span_alarm_control, bound to every instance.
 * assumes one clock domain and the shortened span counts of the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module span_alarm_chk
    import span_alarm_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic spanKey,
    input wire logic [15:0] cellSensitivityNa,
    input wire logic spanActive,
    input wire logic spanFailedMessage,
    input wire logic calibration_failed_flag,
    input wire logic systemAlarmRelay,
    input wire logic first_concentration_alarm,
    input wire logic firstAlarmRelay
);
    default clocking ck @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_ready_now: assert property (psel && penable |-> pready && !pslverr)
        else $error("apb access not answered at once");
    a_flag_sticky: assert property (calibration_failed_flag |=> calibration_failed_flag)
        else $error("failure flag dropped");
    a_sysalarm_sticky: assert property (systemAlarmRelay |=> systemAlarmRelay)
        else $error("system alarm dropped");
    a_reject_raises: assert property ($rose(calibration_failed_flag) |->
        $rose(systemAlarmRelay))
        else $error("reject without system alarm");
    a_reject_cause: assert property ($rose(calibration_failed_flag) |->
        $past(cellSensitivityNa) < SENS_MIN_NA)
        else $error("span rejected with good sensitivity");
    a_failmsg_follows: assert property ($rose(calibration_failed_flag) |->
        spanFailedMessage)
        else $error("no failure message on reject");
    a_failmsg_length: assert property ($rose(spanFailedMessage) |->
        spanFailedMessage[*8] ##[1:4] !spanFailedMessage)
        else $error("failure message length wrong");
    a_span_start: assert property (spanKey && !spanActive && !spanFailedMessage |=>
        spanActive)
        else $error("span key ignored in analyze");
    a_quiet_in_span: assert property (spanActive ##1 spanActive |->
        !first_concentration_alarm)
        else $error("alarm active outside analyze");
    a_relay_cause: assert property ($changed(firstAlarmRelay) |->
        $changed(first_concentration_alarm) || $past(psel && penable && pwrite) ||
        $past(psel && penable && pwrite, 2))
        else $error("relay moved without cause");
    c_reject: cover property ($rose(calibration_failed_flag));
    c_span_done: cover property ($fell(spanActive) && !spanFailedMessage);
    c_trip: cover property ($rose(first_concentration_alarm));
endmodule : span_alarm_chk
bind span_alarm_control span_alarm_chk chk_i (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .spanKey(spanKey),
    .cellSensitivityNa(cellSensitivityNa), .spanActive(spanActive),
    .spanFailedMessage(spanFailedMessage), .calibration_failed_flag(calibration_failed_flag),
    .systemAlarmRelay(systemAlarmRelay), .first_concentration_alarm(first_concentration_alarm),
    .firstAlarmRelay(firstAlarmRelay));
`default_nettype wire

// >>> tb/keypad_model.sv
/*
 * front-panel keypad model: one-cycle key pulses on request.
 * assumes clk is the device clock; keys change just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module keypad_model (
    input wire logic clk,
    output logic spanKey,
    output logic enterKey,
    output logic analyzeKey
);
    initial begin
        spanKey = 1'b0;
        enterKey = 1'b0;
        analyzeKey = 1'b0;
    end
    // 0 span, 1 enter, 2 analyze
    task automatic press(input int k);
        @(posedge clk);
        spanKey <= (k == 0);
        enterKey <= (k == 1);
        analyzeKey <= (k == 2);
        @(posedge clk);
        {spanKey, enterKey, analyzeKey} <= 3'h0;
    endtask : press
endmodule : keypad_model
`default_nettype wire

// >>> tb/span_alarm_control_tb.sv
/*
 * self-checking bench for span_alarm_control with shortened span counts.
 * assumes the keypad model and the bound checker are compiled with it.
 */
`timescale 1ns/1ps
`default_nettype none
module span_alarm_control_tb;
    import span_alarm_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [23:0] reading = 24'h0;
    logic [15:0] cellSensitivityNa = 16'h0258;
    logic [23:0] spanCalIn = 24'h000111;
    logic ramp = 1'b0;
    logic [31:0] prdata, rd;
    logic [23:0] spanCal;
    logic pready, pslverr, spanKey, enterKey, analyzeKey, spanActive, spanFailedMessage;
    logic calibration_failed_flag, systemAlarmRelay, first_concentration_alarm;
    logic second_concentration_alarm, firstAlarmRelay, secondAlarmRelay;
    int failures = 0;
    int samples_checked = 0;
    int n;
    wire logic [3:0] alarms = {first_concentration_alarm, second_concentration_alarm,
        firstAlarmRelay, secondAlarmRelay};
    span_alarm_control #(.MINUTE_PERIOD(20), .FAIL_PERIOD(10), .SAMPLE_PERIOD(4)) dut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .spanKey(spanKey), .enterKey(enterKey), .analyzeKey(analyzeKey), .reading(reading),
        .cellSensitivityNa(cellSensitivityNa), .spanCalIn(spanCalIn), .spanCal(spanCal),
        .spanActive(spanActive), .spanFailedMessage(spanFailedMessage),
        .calibration_failed_flag(calibration_failed_flag), .systemAlarmRelay(systemAlarmRelay),
        .first_concentration_alarm(first_concentration_alarm),
        .second_concentration_alarm(second_concentration_alarm),
        .firstAlarmRelay(firstAlarmRelay), .secondAlarmRelay(secondAlarmRelay));
    keypad_model pad (.clk(clk), .spanKey(spanKey), .enterKey(enterKey), .analyzeKey(analyzeKey));
    always #25 clk = ~clk;
    always @(posedge clk) if (ramp) reading <= reading + 24'h000002;
    task automatic print_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        samples_checked++;
        if (a !== e) begin
            failures++;
            $display("[ERR] %0t exp %h got %h", $time, e, a);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 16 && pready !== 1'b1; k++) @(posedge clk);
        if (k == 16) begin
            failures++;
            print_verdict();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle(input logic [23:0] r);
        @(posedge clk);
        reading <= r;
        repeat (3) @(posedge clk);
    endtask : settle
    task automatic t_reset();
        apb(1'b0, SPAN_CTRL_ADDR, 32'h0);
        chk(32'h0000_0501, rd);
        apb(1'b0, ALARM_CFG1_ADDR, 32'h0);
        chk(32'h1, rd);
        apb(1'b0, ALARM_SET1_ADDR, 32'h0);
        chk(32'h64, rd);
        apb(1'b0, 8'h24, 32'h0);
        chk(32'h0, rd);
        apb(1'b1, SPAN_CTRL_ADDR, 32'h0000_3D01);
        apb(1'b0, SPAN_CTRL_ADDR, 32'h0);
        chk(32'h0000_0501, rd);
    endtask : t_reset
    task automatic t_alarms();
        apb(1'b1, ALARM_CFG1_ADDR, 32'h0);
        settle(24'h000065);
        chk(4'hA, alarms);
        settle(24'h000064);
        chk(4'h0, alarms);
        settle(24'h000063);
        chk(4'h5, alarms);
        apb(1'b1, ALARM_CFG1_ADDR, 32'h4);
        settle(24'h000063);
        chk(4'h4, alarms);
        settle(24'h000064);
        chk(4'h1, alarms);
        apb(1'b1, ALARM_CFG0_ADDR, 32'h3);
        settle(24'h000096);
        chk(4'h1, alarms);
        apb(1'b1, ALARM_SET0_ADDR, 32'hC8);
        apb(1'b1, ALARM_CFG0_ADDR, 32'h1);
        settle(24'h0000C8);
        chk(4'h1, alarms);
        settle(24'h0000C9);
        chk(4'hB, alarms);
    endtask : t_alarms
    task automatic t_latch_pwd();
        apb(1'b1, ALARM_CFG0_ADDR, 32'h9);
        settle(24'h0000C9);
        settle(24'h000096);
        chk(1'b1, first_concentration_alarm);
        apb(1'b1, ALARM_CFG0_ADDR, 32'hB);
        apb(1'b1, ALARM_CFG0_ADDR, 32'h9);
        settle(24'h000096);
        chk(1'b0, first_concentration_alarm);
        settle(24'h0000C9);
        settle(24'h000096);
        apb(1'b1, ALARM_CFG0_ADDR, 32'h1);
        apb(1'b1, ALARM_CFG0_ADDR, 32'h9);
        settle(24'h000096);
        chk(1'b0, first_concentration_alarm);
        apb(1'b1, SPAN_CTRL_ADDR, 32'h0000_0503);
        apb(1'b1, ALARM_CFG0_ADDR, 32'h2);
        apb(1'b0, ALARM_CFG0_ADDR, 32'h0);
        chk(32'h9, rd);
        apb(1'b1, PASSWORD_ADDR, PASSWORD_DEFAULT);
        apb(1'b1, ALARM_CFG0_ADDR, 32'h1);
        apb(1'b0, ALARM_CFG0_ADDR, 32'h0);
        chk(32'h1, rd);
    endtask : t_latch_pwd
    task automatic t_span_auto();
        apb(1'b1, SPAN_CTRL_ADDR, 32'h0000_0101);
        apb(1'b1, SPAN_GAS_ADDR, 32'h3E8);
        settle(24'h0003E8);
        pad.press(0);
        @(posedge clk);
        for (n = 0; n < 200 && spanActive === 1'b1; n++) @(posedge clk);
        chk(1'b1, n >= 20 && n <= 30);
        chk(32'h3E8, {8'h0, spanCal});
        // analyze key aborts a span and re-arms the alarms
        pad.press(0);
        pad.press(2);
        repeat (3) @(posedge clk);
        chk(2'h1, {spanActive, first_concentration_alarm});
    endtask : t_span_auto
    task automatic t_span_fail();
        cellSensitivityNa <= 16'h0190;
        spanCalIn <= 24'h000222;
        apb(1'b1, SPAN_CTRL_ADDR, 32'h0000_3C00);
        pad.press(0);
        ramp <= 1'b1;
        repeat (12) @(posedge clk);
        apb(1'b0, SLOPE_ADDR, 32'h0);
        chk(32'h8, rd);
        ramp <= 1'b0;
        // confirm only once the reading has stopped moving
        repeat (8) @(posedge clk);
        pad.press(1);
        for (n = 0; n < 8 && spanFailedMessage !== 1'b1; n++) @(posedge clk);
        chk(3'h7, {spanFailedMessage, calibration_failed_flag, systemAlarmRelay});
        chk(24'h000222, spanCal);
        for (n = 0; n < 40 && spanFailedMessage === 1'b1; n++) @(posedge clk);
        chk(2'h1, {spanActive, n >= 9 && n <= 11});
        cellSensitivityNa <= 16'h0258;
        apb(1'b1, SPAN_GAS_ADDR, 32'h7D0);
        pad.press(0);
        pad.press(1);
        @(posedge clk);
        for (n = 0; n < 8 && spanActive === 1'b1; n++) @(posedge clk);
        chk(1'b0, spanActive);
        chk(24'h0007D0, spanCal);
        chk(2'h3, {calibration_failed_flag, systemAlarmRelay});
        reset_n <= 1'b0;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk(2'h0, {calibration_failed_flag, systemAlarmRelay});
    endtask : t_span_fail
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_alarms();
        t_latch_pwd();
        t_span_auto();
        t_span_fail();
        print_verdict();
    end
endmodule : span_alarm_control_tb
`default_nettype wire
